// ---- ccc_params.svh ----
// Purpose: constants of the channel calibration and configuration register bank
// Assumes: register port addressed by register index, 16-bit data
// Notes: offsets are register indices, not byte addresses
//
// What this block does
// - channel 0 offset bits 7:0 sit in offset low bits 15:8; high word gives 23:8.
// - channel 1 offset high word holds bits 23:8; whole offset is signed.
// - calibration low registers read zero in bits 7:0 whatever was written.
// - channel 0 gain bits 23:8 in gain high, bits 7:0 in gain low 15:8.
// - gain is an unsigned 24-bit fraction from zero to just below two.
// - gain high resets to 8000h, gain low resets to 0000h.
// - offset registers reset to 0000h; the other offset halves come from input ports, so correction starts from those inputs.
// - channel 1 config bits 15:6 hold signed phase delay, reset zero.
// - config bit 2 set bypasses the DC block for channel 1 only.
// - config bits 1:0 select external pair, shorted, positive or negative test.
// - config bits 5:3 are reserved and always read 000b.
// - global 4-bit DC-block setting governs channel when its bypass bit is clear.
`ifndef CCC_PARAMS_SVH
`define CCC_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------------
`define CCC_ADDR_CHAN0_OFFSET_LOW 8'h0B
`define CCC_ADDR_CHAN0_GAIN_HIGH 8'h0C
`define CCC_ADDR_CHAN0_GAIN_LOW 8'h0D
`define CCC_ADDR_CHAN1_CONFIG 8'h0E
`define CCC_ADDR_CHAN1_OFFSET_HIGH 8'h0F

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CCC_CAL_LOW_MSB 15
`define CCC_CAL_LOW_LSB 8
`define CCC_PHASE_MSB 15
`define CCC_PHASE_LSB 6
`define CCC_BYPASS_BIT 2
`define CCC_INSEL_MSB 1
`define CCC_INSEL_LSB 0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CCC_RST_OFFSET_LOW 8'h00
`define CCC_RST_GAIN_HIGH 16'h8000
`define CCC_RST_GAIN_LOW 8'h00
`define CCC_RST_PHASE 10'h000
`define CCC_RST_BYPASS 1'h0
`define CCC_RST_INSEL 2'h0
`define CCC_RST_OFFSET_HIGH 16'h0000

`endif

// ---- ccc_pkg.sv ----
// Purpose: types shared by the register bank and its helpers
// Assumes: nothing beyond the constants header
// Notes: reserved bits are not stored at all, so they cannot leak on read
package ccc_pkg;

    // ------------------------------------------------------------------------
    // channel input selection
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCC_IN_EXTERNAL = 2'b00,
        CCC_IN_SHORTED = 2'b01,
        CCC_IN_TEST_POS = 2'b10,
        CCC_IN_TEST_NEG = 2'b11
    } ccc_input_e;

    // ------------------------------------------------------------------------
    // register bank state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] chan0_offset_low_bits;
        logic [15:0] chan0_gain_high_bits;
        logic [7:0] chan0_gain_low_bits;
        logic [9:0] chan1_phase_delay;
        logic chan1_dc_block_bypass;
        logic [1:0] chan1_input_select;
        logic [15:0] chan1_offset_high_bits;
        logic [15:0] rdata;
        logic unmapped;
        logic changed;
    } ccc_state_s;

    typedef logic [15:0] ccc_word_t;

endpackage

// ---- ccc_cal_word.sv ----
// Purpose: joins a high word and a low byte into one 24-bit calibration value
// Assumes: both parts are stable register contents
// Notes: output is registered, one cycle behind the register bank
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_cal_word
    import ccc_pkg::*;
#(
    parameter bit SIGNED_WORD = 1'b1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [15:0] high_bits,
    input wire logic [7:0] low_bits,
    output logic [23:0] word,
    output logic negative
);

    typedef struct packed {
        logic [23:0] word;
        logic negative;
    } ccc_cal_s;

    ccc_cal_s state_reg;
    ccc_cal_s state_next;

    always_comb begin
        state_next.word = {high_bits, low_bits};
        // offsets are two's complement, gains are unsigned fractions
        state_next.negative = SIGNED_WORD ? high_bits[15] : 1'b0;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign word = state_reg.word;
    assign negative = state_reg.negative;

endmodule

// ---- ccc_cfg_decode.sv ----
// Purpose: turns channel 1 configuration fields into steering signals
// Assumes: global DC-block setting comes from outside this bank
// Notes: outputs registered; one-hot input routing, exactly one bit high
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_cfg_decode
    import ccc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic bypass,
    input wire logic [1:0] input_select,
    input wire logic [3:0] global_dc_block_setting,
    output logic [3:0] dc_block_setting,
    output logic dc_block_active,
    output logic [3:0] input_route
);

    typedef struct packed {
        logic [3:0] dc_block_setting;
        logic dc_block_active;
        logic [3:0] input_route;
    } ccc_dec_s;

    ccc_dec_s state_reg;
    ccc_dec_s state_next;

    always_comb begin
        state_next = '0;
        if (bypass) begin
            state_next.dc_block_setting = 4'h0;
            state_next.dc_block_active = 1'b0;
        end else begin
            state_next.dc_block_setting = global_dc_block_setting;
            // a zero global setting means the filter is off
            state_next.dc_block_active = |global_dc_block_setting;
        end
        case (ccc_input_e'(input_select))
            CCC_IN_EXTERNAL: state_next.input_route = 4'h1;
            CCC_IN_SHORTED: state_next.input_route = 4'h2;
            CCC_IN_TEST_POS: state_next.input_route = 4'h4;
            CCC_IN_TEST_NEG: state_next.input_route = 4'h8;
            default: state_next.input_route = 4'h1;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '{dc_block_setting: 4'h0, dc_block_active: 1'b0,
                           input_route: 4'h1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign dc_block_setting = state_reg.dc_block_setting;
    assign dc_block_active = state_reg.dc_block_active;
    assign input_route = state_reg.input_route;

endmodule

// ---- ccc_regs.sv ----
// Purpose: channel 0 calibration and channel 1 configuration register bank
// Assumes: one-cycle read/write strobes, never both at once, addr is register index
// Notes: read data stand in the cycle after the read strobe only; unmapped reads 0
`timescale 1ns/1ps
`include "ccc_params.svh"
module ccc_regs
    import ccc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [15:0] rdata,
    output logic unmapped_access,
    input wire logic [15:0] chan0_offset_high_bits,
    input wire logic [7:0] chan1_offset_low_bits,
    input wire logic [3:0] global_dc_block_setting,
    output logic [23:0] chan0_offset,
    output logic chan0_offset_negative,
    output logic [23:0] chan0_gain,
    output logic [23:0] chan1_offset,
    output logic chan1_offset_negative,
    output logic [9:0] chan1_phase_delay,
    output logic chan1_dc_block_bypass,
    output logic [1:0] chan1_input_select,
    output logic [3:0] chan1_dc_block_setting,
    output logic chan1_dc_block_active,
    output logic [3:0] chan1_input_route,
    output logic config_changed
);

    // ------------------------------------------------------------------------
    // reset state
    // ------------------------------------------------------------------------
    localparam ccc_state_s RESET_STATE = '{
        chan0_offset_low_bits: `CCC_RST_OFFSET_LOW,
        chan0_gain_high_bits: `CCC_RST_GAIN_HIGH,
        chan0_gain_low_bits: `CCC_RST_GAIN_LOW,
        chan1_phase_delay: `CCC_RST_PHASE,
        chan1_dc_block_bypass: `CCC_RST_BYPASS,
        chan1_input_select: `CCC_RST_INSEL,
        chan1_offset_high_bits: `CCC_RST_OFFSET_HIGH,
        rdata: 16'h0000,
        unmapped: 1'b0,
        changed: 1'b0
    };

    ccc_state_s state_reg;
    ccc_state_s state_next;

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        begin
            case (a)
                `CCC_ADDR_CHAN0_OFFSET_LOW,
                `CCC_ADDR_CHAN0_GAIN_HIGH,
                `CCC_ADDR_CHAN0_GAIN_LOW,
                `CCC_ADDR_CHAN1_CONFIG,
                `CCC_ADDR_CHAN1_OFFSET_HIGH: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    // low calibration words keep only their top byte; bits 7:0 are never stored
    function automatic ccc_word_t cal_low_view(input logic [7:0] b);
        begin
            cal_low_view = {b, 8'h00};
        end
    endfunction

    function automatic ccc_word_t config_view(input ccc_state_s s);
        begin
            config_view = {s.chan1_phase_delay, 3'h0, s.chan1_dc_block_bypass,
                           s.chan1_input_select};
        end
    endfunction

    function automatic ccc_word_t read_word(input ccc_state_s s, input logic [7:0] a);
        begin
            case (a)
                `CCC_ADDR_CHAN0_OFFSET_LOW: read_word = cal_low_view(s.chan0_offset_low_bits);
                `CCC_ADDR_CHAN0_GAIN_HIGH: read_word = s.chan0_gain_high_bits;
                `CCC_ADDR_CHAN0_GAIN_LOW: read_word = cal_low_view(s.chan0_gain_low_bits);
                `CCC_ADDR_CHAN1_CONFIG: read_word = config_view(s);
                `CCC_ADDR_CHAN1_OFFSET_HIGH: read_word = s.chan1_offset_high_bits;
                default: read_word = 16'h0000;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.changed = 1'b0;
        // read data last one cycle; idle cycles show zero
        state_next.rdata = 16'h0000;
        if (wr_strobe) begin
            case (addr)
                `CCC_ADDR_CHAN0_OFFSET_LOW: begin
                    state_next.chan0_offset_low_bits =
                        wdata[`CCC_CAL_LOW_MSB:`CCC_CAL_LOW_LSB];
                end
                `CCC_ADDR_CHAN0_GAIN_HIGH: begin
                    state_next.chan0_gain_high_bits = wdata;
                end
                `CCC_ADDR_CHAN0_GAIN_LOW: begin
                    state_next.chan0_gain_low_bits =
                        wdata[`CCC_CAL_LOW_MSB:`CCC_CAL_LOW_LSB];
                end
                `CCC_ADDR_CHAN1_CONFIG: begin
                    state_next.chan1_phase_delay =
                        wdata[`CCC_PHASE_MSB:`CCC_PHASE_LSB];
                    state_next.chan1_dc_block_bypass = wdata[`CCC_BYPASS_BIT];
                    state_next.chan1_input_select =
                        wdata[`CCC_INSEL_MSB:`CCC_INSEL_LSB];
                end
                `CCC_ADDR_CHAN1_OFFSET_HIGH: begin
                    state_next.chan1_offset_high_bits = wdata;
                end
                default: begin
                    state_next.chan1_offset_high_bits = state_reg.chan1_offset_high_bits;
                end
            endcase
            state_next.unmapped = !is_mapped(addr);
        end else if (rd_strobe) begin
            state_next.rdata = read_word(state_reg, addr);
            state_next.unmapped = !is_mapped(addr);
        end
        // downstream filters restart on a real change only, not on rewrites
        state_next.changed = (state_next.chan0_offset_low_bits
                              != state_reg.chan0_offset_low_bits)
                          || (state_next.chan0_gain_high_bits
                              != state_reg.chan0_gain_high_bits)
                          || (state_next.chan0_gain_low_bits
                              != state_reg.chan0_gain_low_bits)
                          || (config_view(state_next) != config_view(state_reg))
                          || (state_next.chan1_offset_high_bits
                              != state_reg.chan1_offset_high_bits);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg <= RESET_STATE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------------
    // combined calibration words
    // ------------------------------------------------------------------------
    ccc_cal_word #(
        .SIGNED_WORD(1'b1)
    ) u_chan0_offset (
        .clock(clock),
        .nrst(nrst),
        .high_bits(chan0_offset_high_bits),
        .low_bits(state_reg.chan0_offset_low_bits),
        .word(chan0_offset),
        .negative(chan0_offset_negative)
    );

    ccc_cal_word #(
        .SIGNED_WORD(1'b0)
    ) u_chan0_gain (
        .clock(clock),
        .nrst(nrst),
        .high_bits(state_reg.chan0_gain_high_bits),
        .low_bits(state_reg.chan0_gain_low_bits),
        .word(chan0_gain),
        .negative()
    );

    ccc_cal_word #(
        .SIGNED_WORD(1'b1)
    ) u_chan1_offset (
        .clock(clock),
        .nrst(nrst),
        .high_bits(state_reg.chan1_offset_high_bits),
        .low_bits(chan1_offset_low_bits),
        .word(chan1_offset),
        .negative(chan1_offset_negative)
    );

    // ------------------------------------------------------------------------
    // channel 1 steering
    // ------------------------------------------------------------------------
    ccc_cfg_decode u_chan1_decode (
        .clock(clock),
        .nrst(nrst),
        .bypass(state_reg.chan1_dc_block_bypass),
        .input_select(state_reg.chan1_input_select),
        .global_dc_block_setting(global_dc_block_setting),
        .dc_block_setting(chan1_dc_block_setting),
        .dc_block_active(chan1_dc_block_active),
        .input_route(chan1_input_route)
    );

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign rdata = state_reg.rdata;
    assign unmapped_access = state_reg.unmapped;
    assign chan1_phase_delay = state_reg.chan1_phase_delay;
    assign chan1_dc_block_bypass = state_reg.chan1_dc_block_bypass;
    assign chan1_input_select = state_reg.chan1_input_select;
    assign config_changed = state_reg.changed;

endmodule

// ---- ccc_regs_monitor.sv ----
// Purpose: port-level checks of the channel calibration register bank
// Assumes: strobes one cycle long and never together
// Notes: derived words are checked one cycle behind their sources
`timescale 1ns/1ps
module ccc_regs_monitor
    import ccc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [15:0] rdata,
    input wire logic unmapped_access,
    input wire logic [15:0] chan0_offset_high_bits,
    input wire logic [7:0] chan1_offset_low_bits,
    input wire logic [3:0] global_dc_block_setting,
    input wire logic [23:0] chan0_offset,
    input wire logic chan0_offset_negative,
    input wire logic [23:0] chan1_offset,
    input wire logic chan1_offset_negative,
    input wire logic [9:0] chan1_phase_delay,
    input wire logic chan1_dc_block_bypass,
    input wire logic [1:0] chan1_input_select,
    input wire logic [3:0] chan1_dc_block_setting,
    input wire logic [3:0] chan1_input_route
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_low_reserved;
        rd_strobe && (addr == 8'h0B || addr == 8'h0D) |=> rdata[7:0] == 8'h00;
    endproperty
    a_low_reserved: assert property (p_low_reserved) else $error("low byte not zero");
    property p_cfg_read;
        rd_strobe && addr == 8'h0E |=> rdata == {chan1_phase_delay, 3'b000,
            chan1_dc_block_bypass, chan1_input_select};
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
    property p_cfg_write;
        wr_strobe && addr == 8'h0E |=> chan1_phase_delay == $past(wdata[15:6])
            && chan1_dc_block_bypass == $past(wdata[2])
            && chan1_input_select == $past(wdata[1:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config fields wrong");
    // gated on sampled nrst: at the release edge the outputs still show reset values
    property p_dc_setting;
        nrst |=> chan1_dc_block_setting ==
            ($past(chan1_dc_block_bypass) ? 4'h0 : $past(global_dc_block_setting));
    endproperty
    a_dc_setting: assert property (p_dc_setting) else $error("dc block wrong");
    property p_route;
        nrst |=> chan1_input_route == (4'h1 << $past(chan1_input_select));
    endproperty
    a_route: assert property (p_route) else $error("input route wrong");
    property p_offset0;
        nrst |=> chan0_offset[23:8] == $past(chan0_offset_high_bits)
            && chan0_offset_negative == chan0_offset[23];
    endproperty
    a_offset0: assert property (p_offset0) else $error("channel 0 offset wrong");
    property p_offset1;
        nrst |=> chan1_offset[7:0] == $past(chan1_offset_low_bits)
            && chan1_offset_negative == chan1_offset[23];
    endproperty
    a_offset1: assert property (p_offset1) else $error("channel 1 offset wrong");
    property p_unmapped;
        rd_strobe && (addr < 8'h0B || addr > 8'h0F) |=> rdata == 16'h0000 && unmapped_access;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
endmodule

bind ccc_regs ccc_regs_monitor u_mon (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
    .unmapped_access(unmapped_access), .chan0_offset_high_bits(chan0_offset_high_bits),
    .chan1_offset_low_bits(chan1_offset_low_bits),
    .global_dc_block_setting(global_dc_block_setting), .chan0_offset(chan0_offset),
    .chan0_offset_negative(chan0_offset_negative), .chan1_offset(chan1_offset),
    .chan1_offset_negative(chan1_offset_negative), .chan1_phase_delay(chan1_phase_delay),
    .chan1_dc_block_bypass(chan1_dc_block_bypass), .chan1_input_select(chan1_input_select),
    .chan1_dc_block_setting(chan1_dc_block_setting), .chan1_input_route(chan1_input_route));

// ---- ccc_regs_tb.sv ----
// Purpose: self-checking bench of the channel calibration register bank
// Assumes: one-cycle strobes, read data in the cycle after the read strobe
// Notes: a short mid-run reset checks that reset values come back
`timescale 1ns/1ps
module ccc_regs_tb
    import ccc_pkg::*;
;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [15:0] rdata;
    logic unmapped_access;
    logic [15:0] chan0_offset_high_bits = 16'h0000;
    logic [7:0] chan1_offset_low_bits = 8'h00;
    logic [3:0] global_dc_block_setting = 4'h0;
    logic [23:0] chan0_offset, chan0_gain, chan1_offset;
    logic chan0_offset_negative, chan1_offset_negative;
    logic [9:0] chan1_phase_delay;
    logic chan1_dc_block_bypass, chan1_dc_block_active;
    logic [1:0] chan1_input_select;
    logic [3:0] chan1_dc_block_setting, chan1_input_route;
    logic config_changed;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] resets [5] = '{16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] full [5] = '{16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7, 16'hFFFF};

    ccc_regs dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata),
        .unmapped_access(unmapped_access), .chan0_offset_high_bits(chan0_offset_high_bits),
        .chan1_offset_low_bits(chan1_offset_low_bits),
        .global_dc_block_setting(global_dc_block_setting), .chan0_offset(chan0_offset),
        .chan0_offset_negative(chan0_offset_negative), .chan0_gain(chan0_gain),
        .chan1_offset(chan1_offset), .chan1_offset_negative(chan1_offset_negative),
        .chan1_phase_delay(chan1_phase_delay), .chan1_dc_block_bypass(chan1_dc_block_bypass),
        .chan1_input_select(chan1_input_select), .chan1_dc_block_setting(chan1_dc_block_setting),
        .chan1_dc_block_active(chan1_dc_block_active), .chan1_input_route(chan1_input_route),
        .config_changed(config_changed));

    always #2.5 clock = ~clock;

    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask

    // derived words lag the register by one more cycle
    task automatic settle();
        @(posedge clock);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic results();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            results();
        end
    end

    // ------------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'h0B + 8'(i), resets[i]);
        check(chan0_gain, 24'h800000);
        for (int i = 0; i < 5; i++) wr(8'h0B + 8'(i), 16'hFFFF);
        for (int i = 0; i < 5; i++) rd(8'h0B + 8'(i), full[i]);
        @(posedge clock);
        chan0_offset_high_bits <= 16'h8123;
        chan1_offset_low_bits <= 8'h5A;
        wr(8'h0B, 16'hAB3C);
        wr(8'h0F, 16'h7FFF);
        wr(8'h0C, 16'h1234);
        wr(8'h0D, 16'h5611);
        settle();
        check(chan0_offset, 24'h8123AB);
        check({23'h0, chan0_offset_negative}, 24'h1);
        check(chan1_offset, 24'h7FFF5A);
        check({23'h0, chan1_offset_negative}, 24'h0);
        check(chan0_gain, 24'h123456);
        rd(8'h0D, 16'h5600);
        @(posedge clock);
        global_dc_block_setting <= 4'h9;
        for (int i = 0; i < 4; i++) begin
            wr(8'h0E, {10'h200 + 10'(i), 3'b111, i[0], i[1:0]});
            #1;
            check({23'h0, config_changed}, 24'h1);
            settle();
            check({23'h0, config_changed}, 24'h0);
            check({14'h0, chan1_phase_delay}, 24'(10'h200 + 10'(i)));
            check({22'h0, chan1_input_select}, 24'(i));
            check({20'h0, chan1_input_route}, 24'(4'h1 << i));
            check({20'h0, chan1_dc_block_setting}, i[0] ? 24'h0 : 24'h9);
            check({23'h0, chan1_dc_block_active}, {23'h0, !i[0]});
            rd(8'h0E, {10'h200 + 10'(i), 3'b000, i[0], i[1:0]});
        end
        wr(8'h10, 16'hFFFF);
        #1;
        check({23'h0, config_changed}, 24'h0);
        rd(8'h10, 16'h0000);
        check({23'h0, unmapped_access}, 24'h1);
        rd(8'h0A, 16'h0000);
        rd(8'h0F, 16'h7FFF);
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++) rd(8'h0B + 8'(i), resets[i]);
        results();
    end
endmodule
